// ### hdl/supervisor_regs.vh
// Function
// - Hold reset until supply stays above trip level for 200 ms.
// - Assert reset whenever the supply drops below the trip level.
// - Each start restarts the watchdog; expiry asserts reset.
// - Two-bit rewritable nonvolatile field selects the watchdog period.
// - Write-protect pin high locks the watchdog period bits.
// - Reset from supply drop or watchdog aborts the bus transaction.
// - During reset accept no bus traffic and start no nonvolatile write.
// - A nonvolatile write already running when reset asserts completes.
// - Set: programming starts at stop after valid write, ends on pin low.
// - Reset: programming starts at stop after valid write, ends on pin low.
// - Period codes: 00 1.4 s, 01 600 ms, 10 200 ms, 11 disabled.
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH

`define CLK_KHZ          125000
`define POR_DELAY_MS     200
`define WD_LONG_MS       1400
`define WD_MID_MS        600
`define WD_SHORT_MS      200

`define WD_SEL_LONG      2'h0
`define WD_SEL_MID       2'h1
`define WD_SEL_SHORT     2'h2
`define WD_SEL_OFF       2'h3
`define WD_SEL_RESET     2'h3

`define SYNC_W           5
`define SYNC_IDLE        5'h03
`define IN_SCL           0
`define IN_SDA           1
`define IN_SUPPLY        2
`define IN_WP            3
`define IN_PROG          4

`define ST_HOLD          1'h0
`define ST_RUN           1'h1

`endif

// ### hdl/supply_supervisor_watchdog.v
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.vh"

module supply_supervisor_watchdog #(
   parameter integer CNT_W      = 28,
   parameter integer POR_CYCLES = `POR_DELAY_MS * `CLK_KHZ,
   parameter integer WD_LONG    = `WD_LONG_MS * `CLK_KHZ,
   parameter integer WD_MID     = `WD_MID_MS * `CLK_KHZ,
   parameter integer WD_SHORT   = `WD_SHORT_MS * `CLK_KHZ
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       scl_in,
   input  wire       sda_in,
   input  wire       supply_ok,
   input  wire       wp_pin,
   input  wire       programming_voltage,
   input  wire       write_enable_latch,
   input  wire       valid_write,
   input  wire       period_write,
   input  wire [1:0] period_data,
   input  wire       nv_write_req,
   input  wire       nv_write_busy,
   output reg        system_reset,
   output reg        system_reset_n,
   output reg        bus_enable,
   output reg        bus_abort,
   output wire       nv_write_start,
   output reg        trip_program,
   output reg        watchdog_period_hi,
   output reg        watchdog_period_lo
);

   // Bus pins rest high, so their stages start high to avoid false edges
   localparam [`SYNC_W-1:0] SYNC_IDLE    = `SYNC_IDLE;
   localparam [1:0]          PERIOD_RESET = `WD_SEL_RESET;

   reg  [`SYNC_W-1:0] sync1;
   reg  [`SYNC_W-1:0] sync2;
   reg  [`SYNC_W-1:0] sync3;
   reg  [`SYNC_W-1:0] filt;
   reg  [`SYNC_W-1:0] filt_d;
   wire [`SYNC_W-1:0] raw_in;
   reg                state;
   reg                next_state;
   reg  [CNT_W-1:0]   hold_cnt;
   reg  [CNT_W-1:0]   wd_cnt;
   reg  [CNT_W-1:0]   wd_limit;
   reg                wd_expire;
   reg                write_seen;
   wire               scl;
   wire               sda;
   wire               supply;
   wire               wp;
   wire               prog;
   wire               start_cond;
   wire               stop_cond;
   wire               por_done;
   wire [1:0]         period;

   assign raw_in[`IN_SCL]    = scl_in;
   assign raw_in[`IN_SDA]    = sda_in;
   assign raw_in[`IN_SUPPLY] = supply_ok;
   assign raw_in[`IN_WP]     = wp_pin;
   assign raw_in[`IN_PROG]   = programming_voltage;

   // Three-stage synchronisers, change taken when stages two and three agree
   genvar g;
   generate
      for (g = 0; g < `SYNC_W; g = g + 1) begin : g_sync
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               sync1[g]  <= SYNC_IDLE[g];
               sync2[g]  <= SYNC_IDLE[g];
               sync3[g]  <= SYNC_IDLE[g];
               filt[g]   <= SYNC_IDLE[g];
               filt_d[g] <= SYNC_IDLE[g];
            end else begin
               sync1[g]  <= raw_in[g];
               sync2[g]  <= sync1[g];
               sync3[g]  <= sync2[g];
               if (sync2[g] == sync3[g]) begin
                  filt[g] <= sync3[g];
               end
               filt_d[g] <= filt[g];
            end
         end
      end
   endgenerate

   assign scl    = filt[`IN_SCL];
   assign sda    = filt[`IN_SDA];
   assign supply = filt[`IN_SUPPLY];
   assign wp     = filt[`IN_WP];
   assign prog   = filt[`IN_PROG];
   assign period = {watchdog_period_hi, watchdog_period_lo};

   // Bus start and stop detection
   assign start_cond = scl & filt_d[`IN_SCL] & filt_d[`IN_SDA] & ~sda;
   assign stop_cond  = scl & filt_d[`IN_SCL] & ~filt_d[`IN_SDA] & sda;

   assign por_done = (hold_cnt == POR_CYCLES[CNT_W-1:0] - 1'b1);

   // Nonvolatile writes start only outside reset; running ones finish
   assign nv_write_start = nv_write_req & (state == `ST_RUN)
                           & ~nv_write_busy;

   // Period selection
   always @* begin
      case (period)
         `WD_SEL_LONG:  wd_limit = WD_LONG[CNT_W-1:0];
         `WD_SEL_MID:   wd_limit = WD_MID[CNT_W-1:0];
         `WD_SEL_SHORT: wd_limit = WD_SHORT[CNT_W-1:0];
         default:       wd_limit = {CNT_W{1'b0}};
      endcase
      wd_expire = (period != `WD_SEL_OFF)
                  && (wd_cnt == wd_limit - 1'b1);
   end

   // Reset state machine
   always @* begin
      next_state = state;
      case (state)
         `ST_HOLD: begin
            if (supply && por_done) begin
               next_state = `ST_RUN;
            end
         end
         `ST_RUN: begin
            if (!supply || wd_expire) begin
               next_state = `ST_HOLD;
            end
         end
         default: next_state = `ST_HOLD;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= `ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Supply-good delay count
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_cnt <= {CNT_W{1'b0}};
      end else if (state != `ST_HOLD || !supply) begin
         hold_cnt <= {CNT_W{1'b0}};
      end else if (!por_done) begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   // Watchdog count
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wd_cnt <= {CNT_W{1'b0}};
      end else if (state != `ST_RUN || next_state != `ST_RUN) begin
         wd_cnt <= {CNT_W{1'b0}};
      end else if (start_cond || period == `WD_SEL_OFF) begin
         wd_cnt <= {CNT_W{1'b0}};
      end else begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end

   // Reset outputs and bus gating
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         system_reset   <= 1'b1;
         system_reset_n <= 1'b0;
         bus_enable     <= 1'b0;
         bus_abort      <= 1'b0;
      end else begin
         system_reset   <= (next_state != `ST_RUN);
         system_reset_n <= (next_state == `ST_RUN);
         bus_enable     <= (next_state == `ST_RUN);
         bus_abort      <= (state == `ST_RUN)
                           && (next_state != `ST_RUN);
      end
   end

   // Watchdog period field, locked while write protect is high
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_period_hi <= PERIOD_RESET[1];
         watchdog_period_lo <= PERIOD_RESET[0];
      end else if (period_write && !wp && state == `ST_RUN) begin
         watchdog_period_hi <= period_data[1];
         watchdog_period_lo <= period_data[0];
      end
   end

   // Trip level programming
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         write_seen   <= 1'b0;
         trip_program <= 1'b0;
      end else begin
         if (valid_write && state == `ST_RUN) begin
            write_seen <= 1'b1;
         end else if (start_cond || stop_cond || state != `ST_RUN) begin
            write_seen <= 1'b0;
         end
         if (!wp) begin
            trip_program <= 1'b0;
         end else if (stop_cond && write_seen && write_enable_latch
                      && prog && state == `ST_RUN) begin
            trip_program <= 1'b1;
         end
      end
   end

endmodule // supply_supervisor_watchdog
`default_nettype wire

// ### bench/supervisor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_sva #(
   parameter integer POR_CYCLES = 200
) (
   input wire clk,
   input wire nrst,
   input wire supply_ok,
   input wire wp_pin,
   input wire period_write,
   input wire system_reset,
   input wire bus_enable,
   input wire bus_abort,
   input wire nv_write_start,
   input wire trip_program,
   input wire watchdog_period_hi,
   input wire watchdog_period_lo
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_drop;
      $fell(supply_ok) ##1 !supply_ok [*6];
   endsequence
   sequence s_locked_write;
      wp_pin [*5] ##0 period_write;
   endsequence
   a_bus_gate: assert property (system_reset |-> !bus_enable)
      else $error("bus open in reset");
   a_nv_gate: assert property (system_reset |-> !nv_write_start)
      else $error("write started in reset");
   a_brownout: assert property (s_drop |-> system_reset)
      else $error("no reset on supply drop");
   a_abort_cause: assert property ($rose(system_reset) |-> bus_abort)
      else $error("no abort on reset");
   a_por_delay: assert property ($fell(system_reset)
      |-> $past(supply_ok, POR_CYCLES)) else $error("reset freed early");
   a_period_hold: assert property (
      $changed({watchdog_period_hi, watchdog_period_lo})
      |-> $past(period_write) || $past(period_write, 2))
      else $error("period changed unasked");
   a_wp_lock: assert property (s_locked_write |=>
      $stable({watchdog_period_hi, watchdog_period_lo}))
      else $error("locked period changed");
   a_trip_end: assert property (!wp_pin [*6] |-> !trip_program)
      else $error("trip stays after pin low");
endmodule // supervisor_sva
bind supply_supervisor_watchdog supervisor_sva #(
   .POR_CYCLES(POR_CYCLES)) supervisor_sva_i (.*);
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic kick,
   output var  logic scl,
   output var  logic sda
);
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Start, then stop, at the link rate
   always @(posedge kick) begin
      sda = 1'h0;
      #40 scl = 1'h0;
      #40 scl = 1'h1;
      #40 sda = 1'h1;
   end
endmodule // host_model
`default_nettype wire

// ### bench/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
   logic clk = 1'h0;
   logic nrst, supply_ok, wp_pin, programming_voltage, write_enable_latch;
   logic valid_write, period_write, nv_write_req, nv_write_busy, kick;
   logic [1:0] period_data;
   wire scl, sda, system_reset, system_reset_n, bus_enable, bus_abort;
   wire nv_write_start, trip_program, watchdog_period_hi, watchdog_period_lo;
   int fail_count, cmp_count;
   always #4 clk = ~clk;
   host_model host_model_i (.kick(kick), .scl(scl), .sda(sda));
   supply_supervisor_watchdog #(.POR_CYCLES(200), .WD_LONG(1400),
      .WD_MID(600), .WD_SHORT(200)) supply_supervisor_watchdog_i (
      .scl_in(scl), .sda_in(sda), .*);
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string n, input logic [1:0] e, input logic [1:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task pulse_kick;
      kick = 1'h1;
      cyc(1);
      kick = 1'h0;
   endtask
   task wr(input logic [1:0] d);
      period_data = d;
      period_write = 1'h1;
      cyc(1);
      period_write = 1'h0;
      cyc(3);
   endtask
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task t_por;
      supply_ok = 1'h1;
      cyc(150);
      chk("reset_hold", 1, system_reset);
      cyc(60);
      chk("reset_free", 1, system_reset_n);
      chk("bus_open", 1, bus_enable);
   endtask
   task t_period;
      wp_pin = 1'h1;
      cyc(6);
      wr(2'h1);
      chk("period_lock", 3, {watchdog_period_hi, watchdog_period_lo});
      wp_pin = 1'h0;
      cyc(6);
      wr(2'h2);
      chk("period_set", 2, {watchdog_period_hi, watchdog_period_lo});
   endtask
   task t_nv;
      nv_write_req = 1'h1;
      cyc(1);
      chk("nv_start", 1, nv_write_start);
      nv_write_busy = 1'h1;
      cyc(1);
      chk("nv_busy", 0, nv_write_start);
      nv_write_busy = 1'h0;
   endtask
   task t_trip;
      write_enable_latch = 1'h1;
      wp_pin = 1'h1;
      programming_voltage = 1'h1;
      cyc(6);
      pulse_kick;
      cyc(8);
      valid_write = 1'h1;
      cyc(1);
      valid_write = 1'h0;
      cyc(20);
      chk("trip_on", 1, trip_program);
      wp_pin = 1'h0;
      programming_voltage = 1'h0;
      cyc(8);
      chk("trip_off", 0, trip_program);
   endtask
   task t_brown;
      supply_ok = 1'h0;
      cyc(5);
      chk("brown_abort", 1, bus_abort);
      cyc(3);
      chk("brown_reset", 1, system_reset);
      chk("brown_bus", 0, bus_enable);
      supply_ok = 1'h1;
      cyc(215);
      chk("brown_free", 0, system_reset);
   endtask
   task t_wd;
      int lim[3] = '{200, 600, 1400};
      logic [1:0] code[3] = '{2'h2, 2'h1, 2'h0};
      for (int i = 0; i < 3; i++) begin
         wr(code[i]);
         repeat (3) begin
            pulse_kick;
            cyc(lim[i] - 40);
         end
         chk("wd_alive", 0, system_reset);
         cyc(60);
         chk("wd_fired", 1, system_reset);
         chk("wd_nv", 0, nv_write_start);
         cyc(230);
         chk("wd_fresh", 0, system_reset);
      end
   endtask
   initial begin
      {nrst, supply_ok, wp_pin, programming_voltage, write_enable_latch} = '0;
      {valid_write, period_write, nv_write_req, nv_write_busy, kick} = '0;
      period_data = 2'h0;
      cyc(16);
      nrst = 1'h1;
      t_por;
      t_period;
      t_nv;
      t_trip;
      t_brown;
      t_wd;
      print_verdict;
   end
   initial begin
      #150000;
      fail_count++;
      print_verdict;
   end
endmodule // supply_supervisor_watchdog_tb
`default_nettype wire
